// [hdl/imdh_ctrl.sv]
// pipeline control for out-of-order divides against interruptible multi-cycle ops
`timescale 1ns/100ps
`default_nettype none
`include "imdh_params.svh"
module imdh_ctrl
	import imdh_pkg::*;
(
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	// auxiliary control register write
	input  wire logic                    aux_we_i,
	input  wire logic [`IMDH_AUX_W-1:0]  aux_wdata_i,
	// issue stage
	input  wire logic                    issue_vld_i,
	input  wire logic [2:0]              issue_op_i,
	input  wire logic [`IMDH_NREG_W-1:0] issue_nreg_i,
	input  wire logic                    issue_aligned_i,
	input  wire logic                    issue_wback_i,
	input  wire logic                    issue_div_i,
	input  wire logic [`IMDH_REG_W-1:0]  issue_rd_i,
	input  wire logic [`IMDH_DIV_LAT_W-1:0] div_lat_i,
	// interrupting sources
	input  wire logic                    irq_i,
	input  wire logic                    fast_interrupt_i,
	input  wire logic                    imprecise_abort_i,
	input  wire logic                    debug_halt_i,
	// store pipeline writeback proposal
	input  wire logic                    st_wr_vld_i,
	input  wire logic [`IMDH_REG_W-1:0]  st_wr_reg_i,
	// control outputs
	output logic                         stall_o,
	output logic                         abandon_o,
	output logic                         ooo_en_o,
	output logic                         multi_busy_o,
	// register bank writes
	output logic                         div_wr_o,
	output logic [`IMDH_REG_W-1:0]       div_wr_reg_o,
	output logic                         st_wr_o,
	output logic [`IMDH_REG_W-1:0]       st_wr_reg_o
);
	logic                        multi;
	imdh_div_e                   div_r, div_nxt;
	logic [`IMDH_DIV_LAT_W-1:0]  cnt_r, cnt_nxt;
	logic [`IMDH_REG_W-1:0]      rd_r, rd_nxt;
	logic                        inord_r, inord_nxt;
	logic                        ooo_r, ooo_nxt;
	logic                        mbusy_r, mbusy_nxt;
	logic                        ldm_r, ldm_nxt;
	logic                        stall_r, stall_nxt;
	logic                        aband_r, aband_nxt;
	logic                        dwr_r, dwr_nxt;
	logic [`IMDH_REG_W-1:0]      dreg_r, dreg_nxt;
	logic                        swr_r, swr_nxt;
	logic [`IMDH_REG_W-1:0]      sreg_r, sreg_nxt;
	logic                        intr, div_fin, ldm_issue;

	imdh_multi_class u_class (
		.op_i      (issue_op_i),
		.nreg_i    (issue_nreg_i),
		.aligned_i (issue_aligned_i),
		.wback_i   (issue_wback_i),
		.multi_o   (multi)
	);

	// mode: the aux control bit selects in-order divide retirement
	always_comb begin
		inord_nxt = inord_r;
		if (aux_we_i)
			inord_nxt = aux_wdata_i[`IMDH_AUX_DIV_INORD];
		// enable kept in its own flop so the output has no gate after it
		ooo_nxt = !inord_nxt;
	end

	// mode registers; out-of-order retirement is the reset default
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			inord_r <= 1'b0;
			ooo_r   <= 1'b1;
		end else begin
			inord_r <= inord_nxt;
			ooo_r   <= ooo_nxt;
		end
	end

	// divide tracker: take, count the latency down, retire for one cycle
	// a second divide offered while one is outstanding is not taken
	// a zero latency request runs the default latency instead
	// code 2'b10 is never entered, so the case carries no default
	always_comb begin
		div_nxt = div_r;
		cnt_nxt = cnt_r;
		rd_nxt  = rd_r;
		div_fin = 1'b0;
		unique case (div_r)
			IMDH_IDLE: begin
				if (issue_vld_i && issue_div_i && !stall_r) begin
					div_nxt = IMDH_BUSY;
					cnt_nxt = (div_lat_i == `IMDH_CNT_ZERO) ? `IMDH_DIV_LAT : div_lat_i;
					rd_nxt  = issue_rd_i;
				end
			end
			IMDH_BUSY: begin
				if (cnt_r <= `IMDH_CNT_ONE)
					div_nxt = IMDH_DONE;
				else
					cnt_nxt = cnt_r - `IMDH_CNT_ONE;
			end
			IMDH_DONE: begin
				div_fin = 1'b1; // result reaches the bank one cycle later, through dwr_r
				div_nxt = IMDH_IDLE;
			end
		endcase
	end

	// divide tracker registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_r <= IMDH_IDLE;
			cnt_r <= `IMDH_CNT_ZERO;
			rd_r  <= '0;
		end else begin
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			rd_r  <= rd_nxt;
		end
	end

	// in-order mode holds issue while a divide is outstanding; the mode
	// written on this edge already counts, so no instruction slips past
	// lower throughput is the price of in-order retirement
	always_comb begin
		stall_nxt = inord_nxt && (div_nxt != IMDH_IDLE);
	end

	// issue stall register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stall_r <= 1'b0;
		end else begin
			stall_r <= stall_nxt;
		end
	end

	// multi-cycle tracking and abandonment; debug halt only cuts a
	// load-multiple, the other sources cut any multi-cycle instruction
	always_comb begin
		intr      = irq_i || fast_interrupt_i || imprecise_abort_i;
		ldm_issue = issue_vld_i && (issue_op_i == IMDH_OP_LOADM) && !stall_r;
		mbusy_nxt = mbusy_r;
		ldm_nxt   = ldm_r;
		aband_nxt = 1'b0;
		if (issue_vld_i && multi && !stall_r) begin
			mbusy_nxt = 1'b1;
			ldm_nxt   = issue_op_i == IMDH_OP_LOADM;
		end else if (!issue_vld_i) begin
			mbusy_nxt = 1'b0;
			ldm_nxt   = 1'b0;
		end
		// an abandon wins over a fresh issue in the same cycle
		if (mbusy_r && intr) begin
			aband_nxt = 1'b1;
			mbusy_nxt = 1'b0;
			ldm_nxt   = 1'b0;
		end else if (ldm_r && debug_halt_i) begin
			aband_nxt = 1'b1;
			mbusy_nxt = 1'b0;
			ldm_nxt   = 1'b0;
		end
	end

	// multi-cycle registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mbusy_r <= 1'b0;
			ldm_r   <= 1'b0;
			aband_r <= 1'b0;
		end else begin
			mbusy_r <= mbusy_nxt;
			ldm_r   <= ldm_nxt;
			aband_r <= aband_nxt;
		end
	end

	// register bank write steering
	always_comb begin
		// divide writes only its own destination
		dwr_nxt  = div_fin;
		dreg_nxt = rd_r;
		// a store write is dropped when its multi-cycle op is abandoned, and when
		// a divide retires while a load-multiple sits in issue, so a handler's
		// first load-multiple never sees a stray register write
		swr_nxt  = st_wr_vld_i && !aband_nxt && !(div_fin && (ldm_r || ldm_issue));
		sreg_nxt = st_wr_reg_i;
	end

	// write steering registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dwr_r  <= 1'b0;
			dreg_r <= '0;
			swr_r  <= 1'b0;
			sreg_r <= '0;
		end else begin
			dwr_r  <= dwr_nxt;
			dreg_r <= dreg_nxt;
			swr_r  <= swr_nxt;
			sreg_r <= sreg_nxt;
		end
	end

	// registered outputs, each straight from its flop
	assign stall_o      = stall_r;
	assign abandon_o    = aband_r;
	assign ooo_en_o     = ooo_r;
	assign multi_busy_o = mbusy_r;
	assign div_wr_o     = dwr_r;
	assign div_wr_reg_o = dreg_r;
	assign st_wr_o      = swr_r;
	assign st_wr_reg_o  = sreg_r;
endmodule
`default_nettype wire

// [hdl/imdh_params.svh]
// constants and notes for the divide / multi-cycle hazard control block
// Notes on behaviour
// - handler-first load-multiple alters only its loaded registers
// - divides retire out of order only when enabled
// - aux control bit 7 set forces in-order divides
// - classify multi-cycle load/store-multiple and table branches
// - multi-cycle op abandonable on irq, fast irq, abort
// - load-multiple interruptible also by debug halt request
// - divide writeback during load-multiple issue touches only destination
`ifndef IMDH_PARAMS_SVH
`define IMDH_PARAMS_SVH
`define IMDH_AUX_W          32
`define IMDH_AUX_DIV_INORD  7
`define IMDH_NREG_W         5
`define IMDH_REG_W          4
`define IMDH_MULTI_MIN      5'h03
`define IMDH_MULTI_PAIR     5'h02
`define IMDH_DIV_LAT_W      4
`define IMDH_DIV_LAT        4'h8
`define IMDH_CNT_ZERO       4'h0
`define IMDH_CNT_ONE        4'h1
`endif

// [hdl/imdh_pkg.sv]
// types for the divide / multi-cycle hazard control block
package imdh_pkg;
	typedef enum logic [1:0] {
		IMDH_IDLE = 2'b00,
		IMDH_BUSY = 2'b01,
		IMDH_DONE = 2'b11
	} imdh_div_e;
	typedef enum logic [2:0] {
		IMDH_OP_OTHER = 3'h0,
		IMDH_OP_LOADM = 3'h1,
		IMDH_OP_STOREM = 3'h2,
		IMDH_OP_TBB = 3'h3,
		IMDH_OP_TBH = 3'h4
	} imdh_op_e;
endpackage

// [hdl/imdh_multi_class.sv]
// classifier for multi-cycle instructions
`timescale 1ns/100ps
`default_nettype none
`include "imdh_params.svh"
module imdh_multi_class
	import imdh_pkg::*;
(
	// decoded instruction
	input  wire logic [2:0]              op_i,
	input  wire logic [`IMDH_NREG_W-1:0] nreg_i,
	input  wire logic                    aligned_i,
	input  wire logic                    wback_i,
	// result
	output logic                         multi_o
);
	logic is_mem;
	// load/store-multiple or table branch decisions
	always_comb begin
		is_mem  = (op_i == IMDH_OP_LOADM) || (op_i == IMDH_OP_STOREM);
		multi_o = 1'b0;
		if (is_mem && nreg_i >= `IMDH_MULTI_MIN)
			multi_o = 1'b1;
		else if (is_mem && nreg_i == `IMDH_MULTI_PAIR && !aligned_i && !wback_i)
			multi_o = 1'b1;
		else if (is_mem && nreg_i == `IMDH_MULTI_PAIR && aligned_i && wback_i)
			multi_o = 1'b1;
		else if (op_i == IMDH_OP_TBB || op_i == IMDH_OP_TBH)
			multi_o = 1'b1;
	end
endmodule
`default_nettype wire

// [tb/imdh_ctrl_properties.sv]
// port assertions for the divide and multi-cycle hazard control
`timescale 1ns/100ps
`default_nettype none
module imdh_ctrl_chk
	import imdh_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        aux_we_i,
	input wire logic [31:0] aux_wdata_i,
	input wire logic        issue_vld_i,
	input wire logic [2:0]  issue_op_i,
	input wire logic        irq_i,
	input wire logic        debug_halt_i,
	input wire logic        stall_o,
	input wire logic        abandon_o,
	input wire logic        ooo_en_o,
	input wire logic        multi_busy_o,
	input wire logic        div_wr_o,
	input wire logic        st_wr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_ooo_off; aux_we_i && aux_wdata_i[7] |=> !ooo_en_o; endproperty
	a_ooo_off: assert property (p_ooo_off) else $error("ooo still on");
	property p_ooo_on; aux_we_i && !aux_wdata_i[7] |=> ooo_en_o; endproperty
	a_ooo_on: assert property (p_ooo_on) else $error("ooo still off");
	property p_stall_mode; stall_o |-> !ooo_en_o; endproperty
	a_stall_mode: assert property (p_stall_mode) else $error("stall in ooo mode");
	property p_stall_end; $fell(stall_o) |-> div_wr_o; endproperty
	a_stall_end: assert property (p_stall_end) else $error("stall ended early");
	property p_stall_len; $rose(stall_o) |-> ##[1:17] !stall_o; endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall too long");
	property p_multi; issue_vld_i && issue_op_i == IMDH_OP_TBH && !multi_busy_o && !stall_o
		|=> multi_busy_o; endproperty
	a_multi: assert property (p_multi) else $error("table branch not busy");
	property p_abandon; multi_busy_o && irq_i |=> abandon_o ##1 !abandon_o; endproperty
	a_abandon: assert property (p_abandon) else $error("no abandon pulse");
	property p_dbg; multi_busy_o && debug_halt_i && issue_op_i == IMDH_OP_LOADM |=> abandon_o;
	endproperty
	a_dbg: assert property (p_dbg) else $error("halt did not abandon");
	property p_st_sup; abandon_o |-> !st_wr_o; endproperty
	a_st_sup: assert property (p_st_sup) else $error("store write on abandon");
	property p_div_ldm; div_wr_o && $past(issue_vld_i) && !$past(stall_o)
		&& $past(issue_op_i) == IMDH_OP_LOADM |-> !st_wr_o; endproperty
	a_div_ldm: assert property (p_div_ldm) else $error("store write at divide retire");
endmodule
bind imdh_ctrl imdh_ctrl_chk u_chk (.clk_i, .sys_rst_i, .aux_we_i, .aux_wdata_i, .issue_vld_i,
	.issue_op_i, .irq_i, .debug_halt_i, .stall_o, .abandon_o, .ooo_en_o, .multi_busy_o,
	.div_wr_o, .st_wr_o);
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the hazard control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import imdh_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, aux_we_i = 0, issue_vld_i = 0, issue_aligned_i = 0;
	logic issue_wback_i = 0, issue_div_i = 0, irq_i = 0, fast_interrupt_i = 0;
	logic imprecise_abort_i = 0, debug_halt_i = 0, st_wr_vld_i = 0;
	logic [31:0] aux_wdata_i = '0;
	logic [2:0] issue_op_i = '0;
	logic [4:0] issue_nreg_i = '0;
	logic [3:0] issue_rd_i = '0, div_lat_i = '0, st_wr_reg_i = '0;
	logic stall_o, abandon_o, ooo_en_o, multi_busy_o, div_wr_o, st_wr_o;
	logic [3:0] div_wr_reg_o, st_wr_reg_o;
	int fail_count = 0, n_compared = 0;
	imdh_ctrl DUT (.clk_i, .sys_rst_i, .aux_we_i, .aux_wdata_i, .issue_vld_i, .issue_op_i,
		.issue_nreg_i, .issue_aligned_i, .issue_wback_i, .issue_div_i, .issue_rd_i,
		.div_lat_i, .irq_i, .fast_interrupt_i, .imprecise_abort_i, .debug_halt_i,
		.st_wr_vld_i, .st_wr_reg_i, .stall_o, .abandon_o, .ooo_en_o, .multi_busy_o,
		.div_wr_o, .div_wr_reg_o, .st_wr_o, .st_wr_reg_o);
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// divide in chosen mode, latency 2, retire timing and destination
	task automatic run_div(logic ino, logic [3:0] rd);
		int n;
		@(posedge clk_i);
		aux_we_i <= 1;
		aux_wdata_i <= {24'h00_0000, ino, 7'h00};
		@(posedge clk_i);
		aux_we_i <= 0;
		{issue_vld_i, issue_div_i, issue_rd_i, div_lat_i} <= {2'b11, rd, 4'h2};
		#1 chk("ooo_en", !ino, ooo_en_o);
		@(posedge clk_i);
		{issue_vld_i, issue_div_i} <= 2'b00;
		#1 chk("stall", ino, stall_o);
		for (n = 1; n < 20 && div_wr_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		chk("div_lat", 4'h4, n);
		chk("div_reg", rd, div_wr_reg_o);
		chk("stall_end", 0, stall_o);
	endtask
	// {op, count, aligned, writeback, expected multi}
	task automatic run_multi();
		logic [10:0] tc [8] = '{11'h219, 11'h111, 11'h117, 11'h114,
			11'h212, 11'h301, 11'h401, 11'h040};
		foreach (tc[i]) begin
			@(posedge clk_i);
			{issue_op_i, issue_nreg_i, issue_aligned_i, issue_wback_i} <= tc[i][10:1];
			issue_vld_i <= 1;
			@(posedge clk_i);
			issue_vld_i <= 0;
			#1 chk("multi", tc[i][0], multi_busy_o);
		end
	endtask
	// each interrupting source against a busy multi-cycle op
	task automatic run_abandon();
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i);
			{issue_vld_i, issue_nreg_i, issue_aligned_i, issue_wback_i} <= {1'b1, 5'h04, 2'b00};
			issue_op_i <= (i == 4) ? IMDH_OP_STOREM : IMDH_OP_LOADM;
			@(posedge clk_i);
			{debug_halt_i, imprecise_abort_i, fast_interrupt_i, irq_i} <= 4'h1 << (i > 3 ? 3 : i);
			{st_wr_vld_i, st_wr_reg_i} <= 5'h15;
			@(posedge clk_i);
			{debug_halt_i, imprecise_abort_i, fast_interrupt_i, irq_i} <= 4'h0;
			{issue_vld_i, st_wr_vld_i} <= 2'b00;
			#1 chk("abandon", i < 4, abandon_o);
			chk("st_wr", i == 4, st_wr_o);
			if (i == 4) chk("st_reg", 4'h5, st_wr_reg_o);
			@(posedge clk_i);
			#1 chk("pulse", 0, abandon_o);
		end
	endtask
	// divide retiring while a load-multiple sits in issue, out-of-order mode
	task automatic run_div_ldm();
		@(posedge clk_i);
		aux_we_i <= 1;
		aux_wdata_i <= '0;
		@(posedge clk_i);
		aux_we_i <= 0;
		{issue_vld_i, issue_div_i, issue_rd_i, div_lat_i} <= {2'b11, 4'ha, 4'h2};
		issue_op_i <= IMDH_OP_OTHER;
		@(posedge clk_i);
		issue_div_i <= 0;
		{issue_op_i, issue_nreg_i} <= {IMDH_OP_LOADM, 5'h04};
		{st_wr_vld_i, st_wr_reg_i} <= 5'h1a;
		repeat (2) @(posedge clk_i);
		#1 chk("st_wr_pass", 1, st_wr_o);
		@(posedge clk_i);
		{issue_vld_i, st_wr_vld_i} <= 2'b00;
		#1 chk("div_wr", 1, div_wr_o);
		chk("div_ldm_reg", 4'ha, div_wr_reg_o);
		chk("st_wr_hold", 0, st_wr_o);
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial forever #5 clk_i = ~clk_i;
	// run takes about 75 cycles
	initial begin
		#10000;
		fail_count++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 0;
		#1 chk("ooo_rst", 1, ooo_en_o);
		run_div(1, 4'h9);
		run_div(0, 4'h3);
		run_multi();
		run_abandon();
		run_div_ldm();
		final_report();
	end
endmodule
`default_nettype wire
